// [rtl/port_cfg.v]
`include "port_cfg_map.vh"
// One port's indirect configuration block and pin control
module port_cfg (
  input  wire       mclk,          // System clock
  input  wire       rstn,          // Async reset, active low
  input  wire       addr_wr,       // Port address register write strobe
  input  wire       ctl_wr,        // Port control register write strobe
  input  wire [7:0] wdata,         // Write data
  output reg  [7:0] addr_ff,       // Port address register readback
  output wire [7:0] ctl_rdata,     // Selected subregister readback
  input  wire       stop_mode,     // Device in stop mode
  input  wire [7:0] pin_in,        // Pin input levels
  input  wire [7:0] gpio_out,      // Port output data
  input  wire [7:0] alt_out,       // Alternate function output data
  input  wire [7:0] alt_oe,        // Alternate function output enable
  output reg  [7:0] pad_out_ff,    // Pad output value
  output reg  [7:0] pad_oe_ff,     // Pad output enable, high drives
  output reg  [7:0] high_drive_ff, // High current drive per pin
  output reg  [7:0] pullup_ff,     // Weak pull-up control per pin
  output reg  [15:0] alt_sel_ff,   // Two-bit alternate choice per pin
  output reg  [7:0] alt_active_ff, // Alternate function in control
  output wire       wake_pulse     // Stop-mode wake event, registered
);
  wire [71:0] flat;               // All subregisters
  wire [7:0]  direction_reg;      // 1 input, 0 output
  wire [7:0]  alt_function_enable_reg; // Alternate enable
  wire [7:0]  open_drain_reg;     // Open-drain enable
  wire [7:0]  high_drive_enable_reg;
  wire [7:0]  wake_source_enable_reg;
  wire [7:0]  pullup_enable_reg;
  wire [7:0]  alt_select_lo_reg;
  wire [7:0]  alt_select_hi_reg;
  reg  [7:0]  nxt_out;            // Next pad value
  reg  [7:0]  nxt_oe;             // Next pad enable
  integer     i;

  // Index decode; each subregister name maps to its slice
  assign direction_reg           = flat[8*`IDX_DIRECTION  +: 8];
  assign alt_function_enable_reg = flat[8*`IDX_ALT_ENABLE +: 8];
  assign open_drain_reg          = flat[8*`IDX_OPEN_DRAIN +: 8];
  assign high_drive_enable_reg   = flat[8*`IDX_HIGH_DRIVE +: 8];
  assign wake_source_enable_reg  = flat[8*`IDX_WAKE_SRC   +: 8];
  assign pullup_enable_reg       = flat[8*`IDX_PULLUP     +: 8];
  assign alt_select_lo_reg       = flat[8*`IDX_ALT_SEL_LO +: 8];
  assign alt_select_hi_reg       = flat[8*`IDX_ALT_SEL_HI +: 8];

  // Address register picks the subregister seen through control
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_ff <= `RST_CLEAR;
    end else if (addr_wr) begin
      addr_ff <= wdata;
    end
  end

  // Subregister storage; reads land one cycle after index settles
  subreg_bank u_bank (
    .mclk     (mclk),
    .rstn     (rstn),
    .wr_en    (ctl_wr),
    .idx      (addr_ff),
    .wdata    (wdata),
    .rdata_ff (ctl_rdata),
    .flat     (flat)
  );

  // Pin mux: alternate function owns the pin only when enabled
  always @* begin
    nxt_out = `RST_CLEAR;
    nxt_oe  = `RST_CLEAR;
    for (i = 0; i < 8; i = i + 1) begin
      if (alt_function_enable_reg[i]) begin
        nxt_out[i] = alt_out[i];
        nxt_oe[i]  = alt_oe[i];
      end else begin
        nxt_out[i] = gpio_out[i];
        nxt_oe[i]  = ~direction_reg[i];
      end
      // Open drain never drives high, even for alternates
      if (open_drain_reg[i] && nxt_out[i]) begin
        nxt_oe[i] = 1'b0;
      end
    end
  end

  // Pad controls; high drive independent of who owns the pin
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pad_out_ff    <= `RST_CLEAR;
      pad_oe_ff     <= `RST_CLEAR;
      high_drive_ff <= `RST_CLEAR;
      pullup_ff     <= `RST_CLEAR;
      alt_sel_ff    <= {`RST_CLEAR, `RST_CLEAR};
      alt_active_ff <= `RST_CLEAR;
    end else begin
      pad_out_ff    <= nxt_out;
      pad_oe_ff     <= nxt_oe;
      high_drive_ff <= high_drive_enable_reg;
      pullup_ff     <= pullup_enable_reg;
      for (i = 0; i < 8; i = i + 1) begin
        alt_sel_ff[2*i +: 2] <= {alt_select_hi_reg[i], alt_select_lo_reg[i]};
      end
      alt_active_ff <= alt_function_enable_reg;
    end
  end

  // Wake detection on enabled pins only
  wake_detect u_wake (
    .mclk      (mclk),
    .rstn      (rstn),
    .stop_mode (stop_mode),
    .pin_in    (pin_in),
    .enable    (wake_source_enable_reg),
    .wake_ff   (wake_pulse)
  );
endmodule // port_cfg

// [shared/port_cfg_map.vh]
`ifndef PORT_CFG_MAP_VH
`define PORT_CFG_MAP_VH
`define IDX_DIRECTION   8'h01
`define IDX_ALT_ENABLE  8'h02
`define IDX_OPEN_DRAIN  8'h03
`define IDX_HIGH_DRIVE  8'h04
`define IDX_WAKE_SRC    8'h05
`define IDX_PULLUP      8'h06
`define IDX_ALT_SEL_LO  8'h07
`define IDX_ALT_SEL_HI  8'h08
`define RST_DIRECTION   8'hFF
`define RST_ALT_ENABLE  8'h00
`define RST_CLEAR       8'h00
`define SUBREG_COUNT    4'h9
`endif

// [rtl/subreg_bank.v]
`include "port_cfg_map.vh"
// Nine eight-bit subregisters with a registered read port
module subreg_bank (
  input  wire       mclk,     // System clock
  input  wire       rstn,     // Async reset, active low
  input  wire       wr_en,    // Write strobe
  input  wire [7:0] idx,      // Subregister index
  input  wire [7:0] wdata,    // Write data
  output reg  [7:0] rdata_ff, // Registered read data
  output wire [71:0] flat     // All subregisters, index times eight
);
  reg [7:0] mem_ff [0:8];     // Storage, entry 0 unused
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_ent
      // Each entry loads only when its own index is addressed
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          mem_ff[g] <= (g == 1) ? `RST_DIRECTION : `RST_CLEAR;
        end else if (wr_en && idx == g && g != 0) begin
          // Entry 0 is a hole: it stays at its reset value and reads zero
          mem_ff[g] <= wdata;
        end
      end
      assign flat[g*8 +: 8] = mem_ff[g];
    end
  endgenerate
  // Read data register; unknown indices read zero
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= `RST_CLEAR;
    end else if (idx < {4'h0, `SUBREG_COUNT}) begin
      rdata_ff <= mem_ff[idx[3:0]];
    end else begin
      rdata_ff <= `RST_CLEAR;
    end
  end
endmodule // subreg_bank

// [rtl/wake_detect.v]
`include "port_cfg_map.vh"
// Per-pin change detector for stop-mode wake
module wake_detect (
  input  wire       mclk,      // System clock
  input  wire       rstn,      // Async reset, active low
  input  wire       stop_mode, // Device is in stop mode
  input  wire [7:0] pin_in,    // Pin levels, synchronous
  input  wire [7:0] enable,    // Wake source enables
  output reg        wake_ff    // One-cycle wake pulse
);
  reg  [7:0] last_ff;           // Previous pin levels
  wire [7:0] change;            // Per-pin transition
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      // Only enabled pins count; others ignored entirely
      assign change[g] = enable[g] & (last_ff[g] ^ pin_in[g]);
    end
  endgenerate
  // Track levels continuously so entry to stop raises no false edge
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_ff <= `RST_CLEAR;
      wake_ff <= 1'b0;
    end else begin
      last_ff <= pin_in;
      wake_ff <= stop_mode & (|change);
    end
  end
endmodule // wake_detect

// [sim/pin_board.sv]
// Board side of the pins: external driver, weak pull-up, floating level
module pin_board (
  input  wire [7:0] pad_out_ff, // Pad value
  input  wire [7:0] pad_oe_ff,  // Pad drives
  input  wire [7:0] pullup_ff,  // Pull-up on
  input  wire [7:0] ext,        // Board value
  input  wire [7:0] ext_en,     // Board drives
  output wire [7:0] pin_in      // Pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pad wins; a floating pin reads high with pull-up on, else the inverse of the pad so stale values never match
  assign pin_in = (pad_oe_ff & pad_out_ff) | (~pad_oe_ff & ext_en & ext)
    | (~pad_oe_ff & ~ext_en & (pullup_ff | ~pad_out_ff));
endmodule // pin_board

// [sim/port_cfg_checker.sv]
module port_cfg_checker (
  input wire        mclk,          // Clock
  input wire        rstn,          // Reset, low
  input wire        addr_wr,       // Index load
  input wire        ctl_wr,        // Subreg write
  input wire [7:0]  wdata,         // Write data
  input wire [7:0]  addr_ff,       // Index
  input wire [7:0]  ctl_rdata,     // Readback
  input wire        stop_mode,     // Stop mode
  input wire [7:0]  high_drive_ff, // Drive
  input wire [7:0]  pullup_ff,     // Pull-up
  input wire [15:0] alt_sel_ff,    // Alt choice
  input wire        wake_pulse     // Wake
);
  timeunit 1ns;
  timeprecision 100ps;
  wire [7:0] sel_lo; // Low select bits
  wire [7:0] sel_hi; // High select bits
  genvar g;
  // Split the interleaved pair
  for (g = 0; g < 8; g = g + 1) begin : g_sel
    assign sel_lo[g] = alt_sel_ff[2*g];
    assign sel_hi[g] = alt_sel_ff[2*g+1];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_high_drive: assert property (
    ctl_wr && addr_ff == 8'h04 |-> ##2 high_drive_ff == $past(wdata, 2)) else $error("bad drive");
  a_pullup_copy: assert property (
    ctl_wr && addr_ff == 8'h06 |-> ##2 pullup_ff == $past(wdata, 2)) else $error("bad pullup");
  a_alt_lo: assert property (
    ctl_wr && addr_ff == 8'h07 |-> ##2 sel_lo == $past(wdata, 2)) else $error("bad sel lo");
  a_alt_hi: assert property (
    ctl_wr && addr_ff == 8'h08 |-> ##2 sel_hi == $past(wdata, 2)) else $error("bad sel hi");
  a_wake_readback: assert property (
    ctl_wr && addr_ff == 8'h05 && !addr_wr ##1 !addr_wr |-> ##1 ctl_rdata == $past(wdata, 2))
    else $error("bad wake readback");
  a_index_load: assert property (
    addr_wr |=> addr_ff == $past(wdata)) else $error("bad index");
  a_unmapped_zero: assert property (
    addr_ff > 8'h08 && $stable(addr_ff) |-> ctl_rdata == 8'h00) else $error("unmapped read");
  a_wake_in_stop: assert property (
    wake_pulse |-> $past(stop_mode) || $past(stop_mode, 2)) else $error("wake outside stop");
endmodule // port_cfg_checker
bind port_cfg port_cfg_checker i_port_cfg_checker (.*);

// [sim/port_cfg_test.sv]
module port_cfg_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk = 0, rstn = 0, addr_wr = 0, ctl_wr = 0, stop_mode = 0; // Controls
  logic [7:0] wdata = 0, gpio_out = 0, alt_out = 0, alt_oe = 0, ext = 0, ext_en = 8'hFF; // Data
  wire  [7:0] addr_ff, ctl_rdata, pin_in, pad_out_ff, pad_oe_ff, high_drive_ff, pullup_ff;
  wire  [7:0] alt_active_ff; // Alt enable copy
  wire [15:0] alt_sel_ff;    // Alt choice
  wire        wake_pulse;    // Wake event
  int         failures = 0, comparisons = 0, cyc = 0, n; // Counters
  logic [15:0] e;            // Expected pair
  port_cfg i_port_cfg (.*);
  pin_board i_pin_board (.*);
  // Free-running clock
  always #12.5 mclk = ~mclk;
  // Hang guard, well above the run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      stop_test;
    end
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Index load, then optional write; returns once readback has settled
  task automatic acc(logic [7:0] idx, logic [7:0] d, logic w);
    @(posedge mclk) {addr_wr, wdata} <= {1'b1, idx};
    @(posedge mclk) {addr_wr, ctl_wr, wdata} <= {1'b0, w, d};
    @(posedge mclk) ctl_wr <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  function automatic logic [7:0] pat(int i);
    return {i[3:0], ~i[3:0]};
  endfunction
  task automatic t_reset;
    for (int i = 4; i < 9; i++) begin
      acc(i, 0, 0);
      chk("reset", ctl_rdata, 0);
    end
    chk("oe", pad_oe_ff, 0);
    $display("reset test done");
  endtask
  task automatic t_regs;
    logic [7:0] lo, hi; // Expected select words
    lo = pat(7);
    hi = pat(8);
    for (int i = 4; i < 9; i++) acc(i, pat(i), 1);
    acc(9, 8'hA5, 1);
    chk("unmapped", ctl_rdata, 0);
    acc(0, 8'h5A, 1);
    chk("index zero", ctl_rdata, 0);
    for (int i = 4; i < 9; i++) begin
      acc(i, 0, 0);
      chk("readback", ctl_rdata, pat(i));
    end
    chk("drive", high_drive_ff, pat(4));
    chk("pullup", pullup_ff, pat(6));
    for (int b = 0; b < 8; b++) e[2*b+:2] = {hi[b], lo[b]};
    chk("alt sel", alt_sel_ff, e);
    $display("register test done");
  endtask
  task automatic watch(logic [7:0] v);
    n = 0;
    @(posedge mclk) ext <= v;
    repeat (5) begin
      @(posedge mclk);
      #1;
      n += (wake_pulse === 1'b1);
    end
  endtask
  task automatic t_wake;
    acc(5, 8'h04, 1);
    @(posedge mclk) stop_mode <= 1'b1;
    watch(8'h08);
    chk("disabled pin", n, 0);
    watch(8'h0C);
    chk("enabled pin", n, 1);
    @(posedge mclk) stop_mode <= 1'b0;
    $display("wake test done");
  endtask
  task automatic t_alt;
    @(posedge mclk) {gpio_out, alt_out, alt_oe} <= {8'h5A, 8'h01, 8'h01};
    acc(1, 0, 1);
    chk("gpio out", pad_out_ff, 8'h5A);
    acc(2, 1, 1);
    chk("alt out", pad_out_ff, 8'h5B);
    chk("oe", pad_oe_ff, 8'hFF);
    chk("alt on", alt_active_ff, 8'h01);
    chk("drive kept", high_drive_ff, pat(4));
    $display("alternate test done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_regs;
    t_wake;
    t_alt;
    stop_test;
  end
endmodule // port_cfg_test
